// ===== flash_port_defines.svh
// Offsets, field positions, reset values and timing counts of the flash bus port
`ifndef FLASH_PORT_DEFINES_SVH
`define FLASH_PORT_DEFINES_SVH
`define REG_CTRL_OFF        12'h000
`define REG_STATUS_OFF      12'h004
`define REG_MODES_OFF       12'h008
`define REG_CMD_OFF         12'h00C
`define REG_CMDADDR_OFF     12'h010
`define REG_RDCFG_OFF       12'h014
`define CTRL_LOCKOUT_BIT    0
`define CTRL_CLRWR_BIT      1
`define ST_READY_BIT        7
`define STATUS_RESET        8'h80
`define RCR_RESET           16'h0000
`define RCR_ASYNC_BIT       15
`define CMD_READ_ARRAY      8'hFF
`define CMD_READ_ID         8'h90
`define CMD_READ_QUERY      8'h98
`define CMD_READ_STATUS     8'h70
`define CMD_CLEAR_STATUS    8'h50
`define CMD_BLOCK_ERASE     8'h20
`define CMD_CHIP_ERASE      8'h30
`define CMD_PROGRAM_A       8'h40
`define CMD_PROGRAM_B       8'h10
`define CMD_CONFIRM         8'hD0
`define CMD_CONFIG          8'h60
`define CMD_RCR_CONFIRM     8'h03
`define CMD_OTP_PROGRAM     8'hC0
`define PART_MSB            21
`define PART_LSB            20
`define PAGE_WORDS          8
`define OP_TIME_NS          2000
`define CLK_PERIOD_NS       10
`define OP_CYCLES           (`OP_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== flash_port_pkg.sv
// Types for the flash bus command port
package flash_port_pkg;
  typedef enum logic [1:0] {
    RD_ARRAY  = 2'b00,
    RD_ID     = 2'b01,
    RD_QUERY  = 2'b10,
    RD_STATUS = 2'b11
  } read_mode_type;
  typedef enum logic [1:0] {
    WSM_IDLE  = 2'b00,
    WSM_SETUP = 2'b01,
    WSM_BUSY  = 2'b10
  } wsm_state_type;
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        addr_valid_n;
    logic        rst_n;
  } flash_ctrl_type;
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } cmd_word_type;
endpackage : flash_port_pkg

// ===== flash_bus_command_port.sv
// Flash bus port: pin decode, command decoder, partition read modes, AXI4-Lite view
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "flash_port_defines.svh"
module flash_bus_command_port
  import flash_port_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Flash pins from host
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        addr_valid_n_i,
  input  wire logic        flash_rst_n_i,
  input  wire logic        program_supply_ok_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_oe_n_o,
  output logic             ready_busy_o,
  output logic             ready_busy_oe_n_o,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Read data source for the array
  input  wire logic [15:0] array_data_i
);

  localparam int OP_CNT = (`OP_CYCLES < 1) ? 1 : `OP_CYCLES;

  // Two-flop synchronisers for pins
  flash_ctrl_type ctl_s1_r;
  flash_ctrl_type ctl_s2_r;
  logic           lock_s1_r;
  logic           lock_s2_r;
  cmd_word_type   bus_s1_r;
  cmd_word_type   bus_s2_r;
  cmd_word_type   bus_prev_r;
  flash_ctrl_type ctl_prev_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_s1_r   <= '1;
      ctl_s2_r   <= '1;
      ctl_prev_r <= '1;
      lock_s1_r  <= 1'b0;
      lock_s2_r  <= 1'b0;
      bus_s1_r   <= '0;
      bus_s2_r   <= '0;
      bus_prev_r <= '0;
    end else begin
      ctl_s1_r   <= '{ce_n_i, oe_n_i, we_n_i, addr_valid_n_i, flash_rst_n_i};
      ctl_s2_r   <= ctl_s1_r;
      ctl_prev_r <= ctl_s2_r;
      lock_s1_r  <= ~program_supply_ok_i;
      lock_s2_r  <= lock_s1_r;
      bus_s1_r   <= '{addr_i, dq_i};
      bus_s2_r   <= bus_s1_r;
      bus_prev_r <= bus_s2_r;
    end
  end

  function automatic logic [1:0] part_of(input logic [21:0] a);
    part_of = a[`PART_MSB:`PART_LSB];
  endfunction : part_of

  // Registers and state
  logic            sw_lockout_r;
  logic [7:0]      status_r [4];
  read_mode_type   mode_r [4];
  logic [15:0]     rcr_r;
  wsm_state_type   wsm_r;
  logic [7:0]      pend_cmd_r;
  logic [1:0]      pend_part_r;
  logic [1:0]      op_part_r;
  logic [15:0]     op_cnt_r;
  cmd_word_type    last_cmd_r;
  logic [2:0]      page_idx_r;
  logic [21:0]     rd_addr_r;

  logic in_reset;
  logic wr_active_prev;
  logic wr_end;
  logic [7:0] cmd;
  logic [1:0] part;
  logic lockout;
  assign in_reset       = ~ctl_s2_r.rst_n;
  assign wr_active_prev = ~ctl_prev_r.ce_n & ~ctl_prev_r.we_n;
  // First rising edge of chip or write enable ends the write
  assign wr_end  = wr_active_prev & (ctl_s2_r.ce_n | ctl_s2_r.we_n) & ~in_reset;
  // Word as it stood while both enables were low; host may release data on the rise
  assign cmd     = bus_prev_r.data[7:0];
  assign part    = part_of(bus_prev_r.addr);
  assign lockout = lock_s2_r | sw_lockout_r;

  // Command decoder and write state machine
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        mode_r[i]   <= RD_ARRAY;
        status_r[i] <= `STATUS_RESET;
      end
      rcr_r       <= `RCR_RESET;
      wsm_r       <= WSM_IDLE;
      pend_cmd_r  <= 8'h00;
      pend_part_r <= 2'h0;
      op_part_r   <= 2'h0;
      op_cnt_r    <= 16'h0000;
      last_cmd_r  <= '0;
    end else if (in_reset) begin
      // Abort, status 80H, default modes
      for (int i = 0; i < 4; i++) begin
        mode_r[i]   <= RD_ARRAY;
        status_r[i] <= `STATUS_RESET;
      end
      rcr_r      <= `RCR_RESET;
      wsm_r      <= WSM_IDLE;
      pend_cmd_r <= 8'h00;
      op_cnt_r   <= 16'h0000;
    end else begin
      if (wsm_r == WSM_BUSY) begin
        if (op_cnt_r == 16'h0000) begin
          wsm_r <= WSM_IDLE;
          status_r[op_part_r][`ST_READY_BIT] <= 1'b1;
        end else begin
          op_cnt_r <= op_cnt_r - 16'h0001;
        end
      end
      if (wr_end) begin
        last_cmd_r <= bus_prev_r;
        // Decoder holds no array location; nothing here writes the array
        case (wsm_r)
          WSM_SETUP: begin
            wsm_r <= WSM_IDLE;
            if (pend_cmd_r == `CMD_CONFIG) begin
              if (cmd == `CMD_RCR_CONFIRM) begin
                rcr_r <= bus_prev_r.addr[15:0];
              end
            end else if (lockout) begin
              status_r[pend_part_r][3] <= 1'b1;
            end else if ((pend_cmd_r == `CMD_PROGRAM_A) || (pend_cmd_r == `CMD_PROGRAM_B)
                         || (pend_cmd_r == `CMD_OTP_PROGRAM) || (cmd == `CMD_CONFIRM)) begin
              wsm_r     <= WSM_BUSY;
              op_part_r <= pend_part_r;
              op_cnt_r  <= 16'(OP_CNT);
              status_r[pend_part_r][`ST_READY_BIT] <= 1'b0;
              mode_r[pend_part_r] <= RD_STATUS;
            end
          end
          default: begin
            if ((wsm_r == WSM_BUSY) && (part == op_part_r)) begin
              // Busy partition answers with status only
              mode_r[part] <= RD_STATUS;
            end else begin
              case (cmd)
                `CMD_READ_ARRAY:  mode_r[part] <= RD_ARRAY;
                `CMD_READ_ID:     mode_r[part] <= RD_ID;
                `CMD_READ_QUERY:  mode_r[part] <= RD_QUERY;
                `CMD_READ_STATUS: mode_r[part] <= RD_STATUS;
                `CMD_CLEAR_STATUS: begin
                  status_r[part] <= status_r[part] & 8'h80;
                end
                `CMD_BLOCK_ERASE, `CMD_CHIP_ERASE, `CMD_PROGRAM_A, `CMD_PROGRAM_B,
                `CMD_OTP_PROGRAM: begin
                  // Single operation at a time
                  if (wsm_r == WSM_IDLE) begin
                    wsm_r       <= WSM_SETUP;
                    pend_cmd_r  <= cmd;
                    pend_part_r <= part;
                  end
                end
                `CMD_CONFIG: begin
                  // Entering setup while busy would drop the running operation
                  if (wsm_r == WSM_IDLE) begin
                    wsm_r       <= WSM_SETUP;
                    pend_cmd_r  <= cmd;
                    pend_part_r <= part;
                  end
                end
                default: ;
              endcase
            end
          end
        endcase
      end
    end
  end

  // Page index for array reads; one word for other modes
  logic rd_array;
  logic rd_start;
  assign rd_array = (mode_r[part_of(bus_s2_r.addr)] == RD_ARRAY);
  assign rd_start = ~ctl_s2_r.addr_valid_n & ~ctl_s2_r.ce_n;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_idx_r <= 3'h0;
      rd_addr_r  <= '0;
    end else if (rd_start) begin
      rd_addr_r  <= bus_s2_r.addr;
      page_idx_r <= rd_array ? bus_s2_r.addr[2:0] : 3'h0;
    end else if (~rd_array) begin
      page_idx_r <= 3'h0;
    end else begin
      page_idx_r <= bus_s2_r.addr[2:0];
    end
  end

  // Data output, driven from flops; reads ignore supply level
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o      <= 16'h0000;
      dq_oe_n_o <= 16'hFFFF;
    end else begin
      case (mode_r[part_of(rd_addr_r)])
        RD_STATUS: dq_o <= {8'h00, status_r[part_of(rd_addr_r)]};
        RD_ID:     dq_o <= last_cmd_r.addr[15:0];
        RD_QUERY:  dq_o <= rcr_r;
        default:   dq_o <= array_data_i;
      endcase
      // Float on reset, standby or output disable
      if (in_reset || ctl_s2_r.ce_n || ctl_s2_r.oe_n || ~ctl_s2_r.we_n) begin
        dq_oe_n_o <= 16'hFFFF;
      end else begin
        dq_oe_n_o <= 16'h0000;
      end
    end
  end

  // Busy pin pulls low while the operation runs, even in standby
  assign ready_busy_o      = 1'b0;
  assign ready_busy_oe_n_o = ~(wsm_r == WSM_BUSY);

  // AXI4-Lite slave
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 12'h000;
      w_data_r     <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      sw_lockout_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (aw_hold_r && w_hold_r) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == `REG_CTRL_OFF) begin
          s_axi_bresp  <= 2'b00;
          sw_lockout_r <= w_data_r[`CTRL_LOCKOUT_BIT];
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `REG_CTRL_OFF:    s_axi_rdata <= {31'h0, sw_lockout_r};
        `REG_STATUS_OFF:  s_axi_rdata <= {status_r[3], status_r[2], status_r[1], status_r[0]};
        `REG_MODES_OFF:   s_axi_rdata <= {22'h0, wsm_r, mode_r[3], mode_r[2], mode_r[1],
                                          mode_r[0]};
        `REG_CMDADDR_OFF: s_axi_rdata <= {10'h0, last_cmd_r.addr};
        `REG_CMD_OFF:     s_axi_rdata <= {16'h0, last_cmd_r.data};
        `REG_RDCFG_OFF:   s_axi_rdata <= {16'h0, rcr_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : flash_bus_command_port

// ===== flash_port_properties.sv
// Concurrent checks on the flash bus command port
`timescale 1ns/1ps
module flash_port_properties (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // Flash pins
  input wire logic        ce_n_i,
  input wire logic        oe_n_i,
  input wire logic        we_n_i,
  input wire logic        addr_valid_n_i,
  input wire logic        flash_rst_n_i,
  input wire logic        program_supply_ok_i,
  input wire logic [15:0] dq_oe_n_o,
  input wire logic        ready_busy_oe_n_o,
  // Register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_sel = !ce_n_i && !oe_n_i && we_n_i && flash_rst_n_i && !addr_valid_n_i;
  oe_float_a: assert property (oe_n_i[*5] |-> dq_oe_n_o == 16'hFFFF)
    else $error("data bus driven with output enable high");
  standby_float_a: assert property (ce_n_i[*5] |-> dq_oe_n_o == 16'hFFFF)
    else $error("data bus driven in standby");
  read_drive_a: assert property (rd_sel[*5] |-> dq_oe_n_o == 16'h0000)
    else $error("data bus not driven during a read");
  reset_abort_a: assert property ((!flash_rst_n_i)[*5] |->
    ready_busy_oe_n_o && dq_oe_n_o == 16'hFFFF) else $error("pin reset left outputs driven");
  busy_hold_a: assert property ($fell(ready_busy_oe_n_o) |-> (!ready_busy_oe_n_o)[*8])
    else $error("operation stopped early");
  busy_end_a: assert property ($fell(ready_busy_oe_n_o) |-> ##[1:260] ready_busy_oe_n_o)
    else $error("operation never finished");
  lock_refuse_a: assert property ((!program_supply_ok_i)[*4] |->
    !$fell(ready_busy_oe_n_o)) else $error("operation started under lockout");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held after acceptance");
  busy_c: cover property ($fell(ready_busy_oe_n_o));
  abort_c: cover property ((!flash_rst_n_i)[*5] ##1 ready_busy_oe_n_o);
  read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : flash_port_properties

bind flash_bus_command_port flash_port_properties props_inst (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i),
  .addr_valid_n_i(addr_valid_n_i), .flash_rst_n_i(flash_rst_n_i),
  .program_supply_ok_i(program_supply_ok_i), .dq_oe_n_o(dq_oe_n_o),
  .ready_busy_oe_n_o(ready_busy_oe_n_o), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ===== flash_host_model.sv
// Host processor model driving the flash pins
`timescale 1ns/1ps
module flash_host_model #(
  parameter int WAKE_CYCLES = 4
) (
  // Clock
  input  wire logic        ref_clk_i,
  // Flash pins
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic             addr_valid_n_o,
  output logic             rst_n_o,
  output logic      [21:0] addr_o,
  output logic      [15:0] dq_o
);
  logic [15:0] wdata_r = 16'h0000;
  logic [15:0] noise_r = 16'hA5C3;
  initial begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_valid_n_o = 1'b1;
    rst_n_o = 1'b1;
    addr_o = 22'h000000;
  end
  // Released data lines carry a changing pattern
  always @(posedge ref_clk_i) noise_r <= ~noise_r;
  assign dq_o = we_n_o ? noise_r : wdata_r;
  task automatic pin_write(input logic [21:0] a, input logic [15:0] d, input logic we_first);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_r <= d;
    addr_valid_n_o <= 1'b0;
    ce_n_o <= 1'b0;
    we_n_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    if (we_first) begin
      we_n_o <= 1'b1;
    end else begin
      ce_n_o <= 1'b1;
    end
    repeat (4) @(posedge ref_clk_i);
    ce_n_o <= 1'b1;
    we_n_o <= 1'b1;
    addr_valid_n_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
  endtask : pin_write
  task automatic pin_set(input logic ce_n, input logic oe_n, input logic [21:0] a);
    @(posedge ref_clk_i);
    ce_n_o <= ce_n;
    oe_n_o <= oe_n;
    addr_o <= a;
    addr_valid_n_o <= ce_n;
    repeat (5) @(posedge ref_clk_i);
  endtask : pin_set
  task automatic pin_reset;
    @(posedge ref_clk_i);
    rst_n_o <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_o <= 1'b1;
    repeat (WAKE_CYCLES) @(posedge ref_clk_i);
  endtask : pin_reset
endmodule : flash_host_model

// ===== tb.sv
// Self-checking testbench of the flash bus command port
`timescale 1ns/1ps
`include "flash_port_defines.svh"
module tb
  import flash_port_pkg::*;
;
  logic          ref_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          supply_ok = 1'b1;
  logic   [15:0] array_data = 16'hC3A5;
  logic          ce_n, oe_n, we_n, av_n, frst_n, rb, rb_oe_n;
  logic          awready, wready, bvalid, arready, rvalid;
  logic   [21:0] addr;
  logic   [15:0] dq_wr, dq_o, dq_oe_n;
  logic    [1:0] bresp, rresp;
  logic   [31:0] rdata;
  logic   [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic   [31:0] wdata = 32'h0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  int            fails = 0, checks_done = 0, cycles = 0;
  logic    [7:0] modes_exp;
  logic    [7:0] cmd_tab [4] = '{`CMD_READ_ID, `CMD_READ_QUERY, `CMD_READ_STATUS, `CMD_READ_ARRAY};
  read_mode_type mode_tab [4] = '{RD_ID, RD_QUERY, RD_STATUS, RD_ARRAY};
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  flash_host_model host_inst (.ref_clk_i(ref_clk_i), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .addr_valid_n_o(av_n), .rst_n_o(frst_n), .addr_o(addr), .dq_o(dq_wr));
  flash_bus_command_port flash_bus_command_port_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_valid_n_i(av_n),
    .flash_rst_n_i(frst_n & ~rst_i),
    .program_supply_ok_i(supply_ok), .addr_i(addr), .dq_i(dq_wr), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n), .ready_busy_o(rb), .ready_busy_oe_n_o(rb_oe_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .array_data_i(array_data));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b) begin
      @(posedge ref_clk_i);
      if (aw && awready) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
      if (bvalid) begin
        bready <= 1'b0;
        b = 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    ar = 1'b1;
    r = 1'b1;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r) begin
      @(posedge ref_clk_i);
      if (ar && arready) begin
        arvalid <= 1'b0;
        ar = 1'b0;
      end
      if (rvalid) begin
        rready <= 1'b0;
        r = 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
  endtask : axi_read
  task automatic end_of_test;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    axi_read(`REG_STATUS_OFF, 32'h80808080, 2'b00);
    axi_read(`REG_MODES_OFF, 32'h0, 2'b00);
    axi_read(12'h100, 32'h0, 2'b10);
    axi_write(`REG_STATUS_OFF, 32'h0000_00FF, 2'b10);
    axi_write(`REG_CTRL_OFF, 32'h1, 2'b00);
    axi_read(`REG_CTRL_OFF, 32'h1, 2'b00);
    axi_write(`REG_CTRL_OFF, 32'h0, 2'b00);
    axi_read(`REG_STATUS_OFF, 32'h80808080, 2'b00);
    modes_exp = 8'h00;
    for (int i = 0; i < 8; i++) begin
      modes_exp[2*(i%4) +: 2] = (i < 4) ? mode_tab[i] : RD_ARRAY;
      host_inst.pin_write({i[1:0], 20'h00010}, {8'h00, cmd_tab[i%4] | {8{i > 3}}}, i[0]);
      axi_read(`REG_MODES_OFF, {24'h0, modes_exp}, 2'b00);
    end
    supply_ok <= 1'b0;
    host_inst.pin_set(1'b0, 1'b0, 22'h300020);
    chk("read enable", 32'h0, {16'h0, dq_oe_n});
    chk("read data", {16'h0, array_data}, {16'h0, dq_o});
    host_inst.pin_set(1'b0, 1'b1, 22'h300020);
    chk("output disable", 32'hFFFF, {16'h0, dq_oe_n});
    host_inst.pin_set(1'b1, 1'b0, 22'h300020);
    chk("standby", 32'hFFFF, {16'h0, dq_oe_n});
    host_inst.pin_set(1'b1, 1'b1, 22'h300020);
    host_inst.pin_write(22'h000040, {8'h00, `CMD_PROGRAM_A}, 1'b1);
    host_inst.pin_write(22'h000040, 16'h1234, 1'b0);
    axi_read(`REG_STATUS_OFF, 32'h80808088, 2'b00);
    chk("busy under lockout", 32'h1, {31'h0, rb_oe_n});
    host_inst.pin_write(22'h000000, {8'h00, `CMD_CLEAR_STATUS}, 1'b1);
    axi_read(`REG_STATUS_OFF, 32'h80808080, 2'b00);
    host_inst.pin_write(22'h004A52, {8'h00, `CMD_CONFIG}, 1'b0);
    host_inst.pin_write(22'h004A52, {8'h00, `CMD_RCR_CONFIRM}, 1'b1);
    axi_read(`REG_RDCFG_OFF, 32'h0000_4A52, 2'b00);
    axi_read(`REG_CMD_OFF, 32'h0000_0003, 2'b00);
    axi_read(`REG_CMDADDR_OFF, 32'h0000_4A52, 2'b00);
    supply_ok <= 1'b1;
    host_inst.pin_write(22'h300000, {8'h00, `CMD_READ_ID}, 1'b1);
    host_inst.pin_write(22'h100000, {8'h00, `CMD_PROGRAM_B}, 1'b1);
    host_inst.pin_write(22'h100000, 16'hBEEF, 1'b1);
    axi_read(`REG_STATUS_OFF, 32'h80800080, 2'b00);
    chk("busy in standby", 32'h0, {31'h0, rb_oe_n});
    chk("busy level", 32'h0, {31'h0, rb});
    host_inst.pin_reset;
    axi_read(`REG_STATUS_OFF, 32'h80808080, 2'b00);
    axi_read(`REG_MODES_OFF, 32'h0, 2'b00);
    axi_read(`REG_RDCFG_OFF, 32'h0, 2'b00);
    chk("busy after abort", 32'h1, {31'h0, rb_oe_n});
    host_inst.pin_write(22'h200000, {8'h00, `CMD_BLOCK_ERASE}, 1'b0);
    host_inst.pin_write(22'h200000, {8'h00, `CMD_CONFIRM}, 1'b0);
    for (int n = 0; n < 400 && rb_oe_n !== 1'b1; n++) @(posedge ref_clk_i);
    chk("operation done", 32'h1, {31'h0, rb_oe_n});
    axi_read(`REG_STATUS_OFF, 32'h80808080, 2'b00);
    end_of_test;
  end
endmodule : tb
